/* File: ajr_checker.sv */
// port checker of the set-point ramp: bus answers, output pacing, stepping
// assumes the request only changes just after an update pulse
`timescale 1ns/10ps
module ajr_checker #(
    parameter int FLOW_W = 12,
    parameter int SPEED_W = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire ajr_pkg::ajr_apb_req_s apb_req,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic signed [FLOW_W-1:0] requested_port_flow,
    input wire logic signed [SPEED_W-1:0] vehicle_speed,
    input wire logic signed [FLOW_W-1:0] ramp_port_flow,
    input wire logic flow_update
);
    import ajr_pkg::*;
    logic [31:0] ctrl_reg, ctrl_next;
    logic [10:0] flow_low;
    logic acc, rd, ramp_on;
    assign acc = apb_req.psel && apb_req.penable;
    assign rd = acc && !apb_req.pwrite;
    assign flow_low = ramp_port_flow[10:0];
    assign ramp_on = ctrl_reg[1:0] inside {2'h1, 2'h2};
    // ====================
    // selector shadow, rebuilt from bus writes
    always_comb begin
        ctrl_next = ctrl_reg;
        if (acc && apb_req.pwrite && apb_req.paddr == OFS_CTRL) begin
            ctrl_next = apb_req.pwdata & CTRL_MASK;
        end
    end
    always_ff @(posedge clk) begin
        ctrl_reg <= reset_n ? ctrl_next : CTRL_RST;
    end
    function automatic int gap(int a, int b);
        return a > b ? a - b : b - a;
    endfunction
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ====================
    // pacing, stepping and bus answers
    AST_HOLD: assert property (!flow_update && $past(reset_n) |-> $stable(ramp_port_flow))
        else $error("flow moved without an update");
    AST_GAP: assert property (flow_update |=> !flow_update [*8])
        else $error("updates too close");
    AST_RANGE: assert property (ramp_port_flow <= 1000 && ramp_port_flow >= -1000)
        else $error("flow beyond full scale");
    AST_PASS: assert property (flow_update && !ramp_on |->
        ramp_port_flow == requested_port_flow) else $error("no pass-through");
    AST_TOWARD: assert property (flow_update && ramp_on |->
        gap(ramp_port_flow, requested_port_flow) <=
        gap($past(ramp_port_flow), requested_port_flow)) else $error("flow moved away");
    AST_NOFLIP: assert property (flow_update && ramp_on && $past(ramp_port_flow) > 0 |->
        ramp_port_flow >= 0) else $error("flow crossed zero in one step");
    AST_BUS: assert property (acc |-> pready && pslverr == (apb_req.paddr > OFS_STATUS))
        else $error("bad bus answer");
    AST_CTRL_RD: assert property (rd && apb_req.paddr == OFS_CTRL |-> prdata == ctrl_reg)
        else $error("selector readback wrong");
    AST_STAT_RD: assert property (rd && apb_req.paddr == OFS_STATUS |->
        prdata[10:0] == $past(flow_low)) else $error("status flow wrong");
endmodule

bind ajr_setpoint_ramp ajr_checker #(.FLOW_W(FLOW_W), .SPEED_W(SPEED_W)) i_ajr_checker (
    .clk, .reset_n, .apb_req, .prdata, .pready, .pslverr, .requested_port_flow,
    .vehicle_speed, .ramp_port_flow, .flow_update);

/* File: ajr_partner.sv */
// steering request source and speed sensor facing the ramp
// assumes bench commands settle one edge before a tick
`timescale 1ns/10ps
module ajr_partner (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic signed [11:0] cmd_flow,
    input wire logic signed [15:0] cmd_speed,
    output logic signed [11:0] requested_port_flow,
    output logic signed [15:0] vehicle_speed
);
    // a new request is launched just after an edge, never mid-cycle
    always_ff @(posedge clk) begin
        requested_port_flow <= reset_n ? cmd_flow : 12'sh000;
        vehicle_speed <= reset_n ? cmd_speed : 16'sh0000;
    end
endmodule

/* File: ajr_pkg.sv */
// constants, register map and carrier types of the anti-jerk set-point ramp
// assumes one 50 mhz clock and a 1 ms control tick derived from it
package ajr_pkg;

    // =========================================================
    // timing
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_PERIOD_US = 1000;
    localparam int TICK_CYCLES_DEF = CLK_HZ / 1_000_000 * TICK_PERIOD_US;

    // =========================================================
    // flow scaling: progress carries 10 fraction bits below per mille
    localparam int FLOW_FULL = 1000;
    localparam int PROG_SH = 10;
    localparam logic [20:0] PROG_FULL = 21'(FLOW_FULL << PROG_SH);
    localparam int TIME_MIN = 1;
    localparam int TIME_MAX = 1000;
    localparam int SHAPE_MAX = 10;
    localparam int ABORT_OFF = 1000;
    // progressive breakpoints: flow per mille at quarter steps of time
    localparam int BRK_STEP = 250;
    localparam int BRK_Y1 = 50;
    localparam int BRK_Y2 = 120;
    localparam int BRK_Y3 = 333;

    // =========================================================
    // register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_UP = 8'h04;
    localparam logic [7:0] OFS_DOWN = 8'h08;
    localparam logic [7:0] OFS_AUX = 8'h0c;
    localparam logic [7:0] OFS_LIMIT = 8'h10;
    localparam logic [7:0] OFS_SPEED = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    // field positions
    localparam int TYPE_LSB = 0;
    localparam int RISE_LSB = 8;
    localparam int FALL_LSB = 16;
    localparam int LO_LSB = 0;
    localparam int HI_LSB = 16;
    localparam int ST_ABORT = 16;
    localparam int ST_FALL = 17;
    localparam int ST_FAST = 18;

    // writable bits and reset values
    localparam logic [31:0] CTRL_MASK = 32'h000f_0f03;
    localparam logic [31:0] PAIR_MASK = 32'h03ff_03ff;
    localparam logic [31:0] LO_MASK = 32'h0000_03ff;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] UP_RST = 32'h00c8_0001;
    localparam logic [31:0] DOWN_RST = 32'h015e_015e;
    localparam logic [31:0] AUX_RST = 32'h0064_0064;
    localparam logic [31:0] LIMIT_RST = 32'h0000_03e8;
    localparam logic [31:0] SPEED_RST = 32'h0000_01f4;

    // =========================================================
    // types
    typedef enum logic [1:0] {
        RAMP_OFF = 2'h0,
        RAMP_FIXED = 2'h1,
        RAMP_SPEED = 2'h2
    } ajr_ramp_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_INTERP = 2'h1,
        ST_STEP = 2'h3,
        ST_APPLY = 2'h2
    } ajr_state_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } ajr_apb_req_s;

endpackage

/* File: ajr_seq_div.sv */
// restoring divider, one quotient bit per clock
// assumes start is a one-cycle pulse; a new start aborts any running division
`timescale 1ns/10ps
module ajr_seq_div #(
    parameter int W = 24
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic [W-1:0] num,
    input wire logic [W-1:0] den,
    output logic [W-1:0] quo,
    output logic done
);
    localparam int CW = $clog2(W + 1);

    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic [W:0] rem_reg, rem_next;
    logic [W-1:0] q_reg, q_next;
    logic [W-1:0] den_reg, den_next;
    logic [W:0] trial;

    if (W < 2) begin : g_bad_width
        $error("divider width too small");
    end

    // =========================================================
    // iteration
    always_comb begin
        busy_next = busy_reg;
        done_next = 1'b0;
        cnt_next = cnt_reg;
        rem_next = rem_reg;
        q_next = q_reg;
        den_next = den_reg;
        trial = {rem_reg[W-1:0], q_reg[W-1]} - {1'b0, den_reg};
        if (start) begin
            busy_next = 1'b1;
            cnt_next = CW'(W);
            rem_next = '0;
            q_next = num;
            den_next = den;
        end else if (busy_reg) begin
            // zero divisor ends with an all-ones quotient
            if (!trial[W]) begin
                rem_next = trial;
                q_next = {q_reg[W-2:0], 1'b1};
            end else begin
                rem_next = {rem_reg[W-1:0], q_reg[W-1]};
                q_next = {q_reg[W-2:0], 1'b0};
            end
            cnt_next = cnt_reg - CW'(1);
            if (cnt_reg == CW'(1)) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            cnt_reg <= '0;
            rem_reg <= '0;
            q_reg <= '0;
            den_reg <= '0;
        end else begin
            busy_reg <= busy_next;
            done_reg <= done_next;
            cnt_reg <= cnt_next;
            rem_reg <= rem_next;
            q_reg <= q_next;
            den_reg <= den_next;
        end
    end

    assign quo = q_reg;
    assign done = done_reg;
endmodule

/* File: ajr_setpoint_ramp.sv */
// anti-jerk slew limiter for the spool port-flow set-point, apb configured
// assumes request and speed come from logic on clk, updated at will
//
// What this block does
// - selector chooses off, fixed or speed ramps
// - selector zero passes request straight through
// - selector two selects speed-dependent ramp times
// - output is the ramp-limited port flow
// - rise time zero-to-full, 1..1000 ms
// - slow fall time full-to-zero, default 350
// - rise curve shape 0 linear, 10 progressive
// - fall curve shape likewise 0 to 10
// - progressive knees 50/120/333 at quarters
// - fast fall above region limit; 1000 disables
// - fast fall time scaled as full-to-zero
// - reverse request beyond threshold aborts slow fall
// - abort threshold 0..1000; zero aborts readily
// - aborted fall continues at abort time
// - abort threshold 1000 disables abort
// - speed mode interpolates standstill and high-speed times
// - high-speed times apply at region limit
// - speed region sets span of variation
// - speed region 0..1000 of 0.1 km/h
`timescale 1ns/10ps
module ajr_setpoint_ramp #(
    parameter int TICK_CYCLES = ajr_pkg::TICK_CYCLES_DEF,
    parameter int FLOW_W = 12,
    parameter int SPEED_W = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire ajr_pkg::ajr_apb_req_s apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic signed [FLOW_W-1:0] requested_port_flow,
    input wire logic signed [SPEED_W-1:0] vehicle_speed,
    output logic signed [FLOW_W-1:0] ramp_port_flow,
    output logic flow_update
);
    import ajr_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int DW = 24;

    // two chained divisions plus sequencing must end well inside one tick
    if (TICK_CYCLES < 64 || FLOW_W < 12 || SPEED_W < 11) begin : g_bad_param
        $error("tick count or port widths out of range");
    end

    // =========================================================
    // helpers
    function automatic logic [9:0] tclamp(input logic [9:0] t);
        if (t < 10'(TIME_MIN))
            return 10'(TIME_MIN);
        return (t > 10'(TIME_MAX)) ? 10'(TIME_MAX) : t;
    endfunction

    function automatic logic [9:0] abs_clamp(input logic [SPEED_W-1:0] v);
        logic [SPEED_W-1:0] m;
        m = v[SPEED_W-1] ? SPEED_W'(-v) : v;
        return (m > SPEED_W'(FLOW_FULL)) ? 10'(FLOW_FULL) : m[9:0];
    endfunction

    // progress to flow: linear blended towards the progressive polyline
    function automatic logic [9:0] curve(input logic [20:0] x, input logic [3:0] shape);
        int f;
        int p;
        int s;
        f = int'(x[19:PROG_SH]);
        s = (shape > 4'(SHAPE_MAX)) ? SHAPE_MAX : int'(shape);
        if (f < BRK_STEP)
            p = f * BRK_Y1 / BRK_STEP;
        else if (f < 2 * BRK_STEP)
            p = BRK_Y1 + (f - BRK_STEP) * (BRK_Y2 - BRK_Y1) / BRK_STEP;
        else if (f < 3 * BRK_STEP)
            p = BRK_Y2 + (f - 2 * BRK_STEP) * (BRK_Y3 - BRK_Y2) / BRK_STEP;
        else
            p = BRK_Y3 + (f - 3 * BRK_STEP) * (FLOW_FULL - BRK_Y3) / BRK_STEP;
        return 10'(f - s * (f - p) / SHAPE_MAX);
    endfunction

    // =========================================================
    // apb slave, zero wait states
    logic [31:0] ctrl_reg, ctrl_next, up_reg, up_next, down_reg, down_next;
    logic [31:0] aux_reg, aux_next, limit_reg, limit_next, speed_reg, speed_next;
    logic [31:0] prdata_reg, prdata_next, status;
    logic addr_ok, access;

    always_comb begin
        unique case (apb_req.paddr)
            OFS_CTRL, OFS_UP, OFS_DOWN, OFS_AUX, OFS_LIMIT, OFS_SPEED, OFS_STATUS:
                addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    assign access = apb_req.psel & apb_req.penable;
    assign pready = 1'b1;
    assign pslverr = access & ~addr_ok;

    always_comb begin
        ctrl_next = ctrl_reg;
        up_next = up_reg;
        down_next = down_reg;
        aux_next = aux_reg;
        limit_next = limit_reg;
        speed_next = speed_reg;
        prdata_next = prdata_reg;
        if (access && apb_req.pwrite) begin
            unique case (apb_req.paddr)
                OFS_CTRL: ctrl_next = apb_req.pwdata & CTRL_MASK;
                OFS_UP: up_next = apb_req.pwdata & PAIR_MASK;
                OFS_DOWN: down_next = apb_req.pwdata & PAIR_MASK;
                OFS_AUX: aux_next = apb_req.pwdata & PAIR_MASK;
                OFS_LIMIT: limit_next = apb_req.pwdata & PAIR_MASK;
                OFS_SPEED: speed_next = apb_req.pwdata & LO_MASK;
                default: ;
            endcase
        end
        // read data is latched in setup so it stands from a flip-flop
        if (apb_req.psel && !apb_req.penable) begin
            unique case (apb_req.paddr)
                OFS_CTRL: prdata_next = ctrl_reg;
                OFS_UP: prdata_next = up_reg;
                OFS_DOWN: prdata_next = down_reg;
                OFS_AUX: prdata_next = aux_reg;
                OFS_LIMIT: prdata_next = limit_reg;
                OFS_SPEED: prdata_next = speed_reg;
                OFS_STATUS: prdata_next = status;
                default: prdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_reg <= CTRL_RST;
            up_reg <= UP_RST;
            down_reg <= DOWN_RST;
            aux_reg <= AUX_RST;
            limit_reg <= LIMIT_RST;
            speed_reg <= SPEED_RST;
            prdata_reg <= 32'h0000_0000;
        end else begin
            ctrl_reg <= ctrl_next;
            up_reg <= up_next;
            down_reg <= down_next;
            aux_reg <= aux_next;
            limit_reg <= limit_next;
            speed_reg <= speed_next;
            prdata_reg <= prdata_next;
        end
    end

    assign prdata = prdata_reg;

    // configuration fields
    logic [1:0] ramp_type;
    logic [3:0] rise_shape, fall_shape;
    logic [9:0] t_rise0, t_riseh, t_fall0, t_fallh, t_fast, t_abort;
    logic [9:0] fast_fall_region_limit, fall_abort_threshold, speed_region;

    assign ramp_type = ctrl_reg[TYPE_LSB +: 2];
    assign rise_shape = ctrl_reg[RISE_LSB +: 4];
    assign fall_shape = ctrl_reg[FALL_LSB +: 4];
    assign t_rise0 = up_reg[LO_LSB +: 10];
    assign t_riseh = up_reg[HI_LSB +: 10];
    assign t_fall0 = down_reg[LO_LSB +: 10];
    assign t_fallh = down_reg[HI_LSB +: 10];
    assign t_fast = aux_reg[LO_LSB +: 10];
    assign t_abort = aux_reg[HI_LSB +: 10];
    assign fast_fall_region_limit = limit_reg[LO_LSB +: 10];
    assign fall_abort_threshold = limit_reg[HI_LSB +: 10];
    assign speed_region = speed_reg[LO_LSB +: 10];

    // =========================================================
    // control tick divider
    logic [TW-1:0] tick_cnt_reg, tick_cnt_next;
    logic tick;

    assign tick = (tick_cnt_reg == TW'(TICK_CYCLES - 1));
    assign tick_cnt_next = tick ? '0 : tick_cnt_reg + TW'(1);

    always_ff @(posedge clk) begin
        if (!reset_n)
            tick_cnt_reg <= '0;
        else
            tick_cnt_reg <= tick_cnt_next;
    end

    // =========================================================
    // ramp decision for the captured request
    ajr_state_e st_reg, st_next;
    logic [9:0] req_mag_reg, req_mag_next, spd_reg, spd_next;
    logic req_neg_reg, req_neg_next;
    logic [9:0] flow_reg, flow_next, time_reg, time_next;
    logic [20:0] x_reg, x_next, step_reg, step_next;
    logic dir_reg, dir_next, abort_reg, abort_next, fast_reg, fast_next;
    logic start_reg, start_next, upd_reg, upd_next;
    logic signed [FLOW_W-1:0] out_reg, out_next;
    logic [DW-1:0] div_num, div_den, div_quo;
    logic div_done;

    logic opposite, go_up, go_down, abort_now, abort_eff, fast_now, need_interp;
    logic [9:0] goal, t0, th, t_direct, t_diff, t_interp;
    logic [3:0] shape_sel;
    logic [19:0] interp_num;
    logic [20:0] x_up, x_dn;
    logic [9:0] f_new;

    always_comb begin
        opposite = (flow_reg != 10'h000) && (req_mag_reg != 10'h000)
                   && (req_neg_reg != dir_reg);
        goal = opposite ? 10'h000 : req_mag_reg;
        go_up = goal > flow_reg;
        go_down = goal < flow_reg;
        // only a slow fall may be aborted; 1000 switches the abort off
        abort_now = go_down && opposite && (flow_reg <= fast_fall_region_limit)
                    && (fall_abort_threshold < 10'(ABORT_OFF))
                    && (req_mag_reg > fall_abort_threshold);
        abort_eff = go_down && (abort_reg || abort_now);
        fast_now = go_down && !abort_eff && (flow_reg > fast_fall_region_limit);
        t0 = go_up ? t_rise0 : t_fall0;
        th = go_up ? t_riseh : t_fallh;
        need_interp = (ramp_type == RAMP_SPEED) && !fast_now && !abort_eff
                      && (speed_region != 10'h000);
        if (fast_now)
            t_direct = t_fast;
        else if (abort_eff)
            t_direct = t_abort;
        else if (ramp_type == RAMP_SPEED)
            t_direct = th;
        else
            t_direct = t0;
        t_diff = (th >= t0) ? th - t0 : t0 - th;
        interp_num = 20'(t_diff) * 20'(spd_reg);
        t_interp = (th >= t0) ? t0 + div_quo[9:0] : t0 - div_quo[9:0];
        shape_sel = go_up ? rise_shape : ((fast_now || abort_eff) ? 4'h0 : fall_shape);
    end

    assign div_num = (st_reg == ST_INTERP) ? DW'(interp_num) : DW'(PROG_FULL);
    assign div_den = (st_reg == ST_INTERP) ? DW'(speed_region) : DW'(time_reg);

    ajr_seq_div #(.W(DW)) u_div (
        .clk(clk),
        .reset_n(reset_n),
        .start(start_reg),
        .num(div_num),
        .den(div_den),
        .quo(div_quo),
        .done(div_done)
    );

    // =========================================================
    // sequence and apply
    always_comb begin
        st_next = st_reg;
        req_mag_next = req_mag_reg;
        req_neg_next = req_neg_reg;
        spd_next = spd_reg;
        flow_next = flow_reg;
        time_next = time_reg;
        x_next = x_reg;
        step_next = step_reg;
        dir_next = dir_reg;
        abort_next = abort_reg;
        fast_next = fast_reg;
        start_next = 1'b0;
        upd_next = 1'b0;
        out_next = out_reg;
        x_up = (x_reg + step_reg > PROG_FULL) ? PROG_FULL : x_reg + step_reg;
        x_dn = (x_reg > step_reg) ? x_reg - step_reg : 21'h000000;
        f_new = curve(go_up ? x_up : x_dn, shape_sel);
        unique case (st_reg)
            ST_IDLE: begin
                if (tick) begin
                    req_mag_next = abs_clamp(SPEED_W'(requested_port_flow));
                    req_neg_next = requested_port_flow[FLOW_W-1];
                    // magnitude only, held at the region edge above it
                    spd_next = (abs_clamp(vehicle_speed) > speed_region)
                               ? speed_region : abs_clamp(vehicle_speed);
                    if (ramp_type == RAMP_FIXED || ramp_type == RAMP_SPEED) begin
                        st_next = ST_INTERP;
                        start_next = 1'b1;
                    end else begin
                        st_next = ST_APPLY;
                    end
                end
            end
            ST_INTERP: begin
                if (!need_interp) begin
                    time_next = tclamp(t_direct);
                    st_next = ST_STEP;
                    start_next = 1'b1;
                end else if (div_done && !start_reg) begin
                    time_next = tclamp(t_interp);
                    st_next = ST_STEP;
                    start_next = 1'b1;
                end
            end
            ST_STEP: begin
                // a stale done from an abandoned division is masked by start
                if (div_done && !start_reg) begin
                    step_next = div_quo[20:0];
                    st_next = ST_APPLY;
                end
            end
            ST_APPLY: begin
                st_next = ST_IDLE;
                upd_next = 1'b1;
                fast_next = 1'b0;
                if (ramp_type != RAMP_FIXED && ramp_type != RAMP_SPEED) begin
                    flow_next = req_mag_reg;
                    dir_next = req_neg_reg;
                    x_next = 21'(req_mag_reg) << PROG_SH;
                    abort_next = 1'b0;
                end else if (go_up) begin
                    // never past the goal, never backwards on a shape change
                    flow_next = (f_new > goal) ? goal : f_new;
                    if (flow_next < flow_reg)
                        flow_next = flow_reg;
                    x_next = (f_new > goal) ? x_reg : x_up;
                end else if (go_down) begin
                    flow_next = (f_new < goal) ? goal : f_new;
                    if (flow_next > flow_reg)
                        flow_next = flow_reg;
                    x_next = (f_new < goal) ? x_reg : x_dn;
                    abort_next = abort_eff;
                    fast_next = fast_now;
                end
                if (flow_next == 10'h000) begin
                    abort_next = 1'b0;
                    x_next = 21'h000000;
                    dir_next = req_neg_reg;
                end
                out_next = dir_next ? -FLOW_W'(flow_next) : FLOW_W'(flow_next);
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_reg <= ST_IDLE;
            req_mag_reg <= 10'h000;
            req_neg_reg <= 1'b0;
            spd_reg <= 10'h000;
            flow_reg <= 10'h000;
            time_reg <= 10'h001;
            x_reg <= 21'h000000;
            step_reg <= 21'h000000;
            dir_reg <= 1'b0;
            abort_reg <= 1'b0;
            fast_reg <= 1'b0;
            start_reg <= 1'b0;
            upd_reg <= 1'b0;
            out_reg <= '0;
        end else begin
            st_reg <= st_next;
            req_mag_reg <= req_mag_next;
            req_neg_reg <= req_neg_next;
            spd_reg <= spd_next;
            flow_reg <= flow_next;
            time_reg <= time_next;
            x_reg <= x_next;
            step_reg <= step_next;
            dir_reg <= dir_next;
            abort_reg <= abort_next;
            fast_reg <= fast_next;
            start_reg <= start_next;
            upd_reg <= upd_next;
            out_reg <= out_next;
        end
    end

    assign status = {13'h0000, fast_reg, 1'b0, abort_reg,
                     out_reg[FLOW_W-1] ? 5'h1f : 5'h00, out_reg[10:0]};
    assign ramp_port_flow = out_reg;
    assign flow_update = upd_reg;
endmodule

/* File: tb.sv */
// bench: drives the ramp over apb and the request port against a stepping model
// assumes a 100-cycle tick; ramp times below count ticks
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
$display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb;
    import ajr_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    ajr_apb_req_s apb_req = '0;
    logic [31:0] prdata, rd, v;
    logic pready, pslverr, err, flow_update;
    logic signed [11:0] cmd_flow = 12'sh000, requested_port_flow, ramp_port_flow;
    logic signed [15:0] cmd_speed = 16'sh0000, vehicle_speed;
    logic [31:0] rst_v [7] = '{CTRL_RST, UP_RST, DOWN_RST, AUX_RST, LIMIT_RST, SPEED_RST, 32'h0};
    int knee [4] = '{50, 120, 333, 1000};
    int mismatches = 0, comparisons = 0, cycles = 0;
    int cur = 0, tr = 1, tf = 1, tfast = 1, tra = 1, lim = 1000, thr = 0, mode = 0, prog = 0, ab = 0;
    always #10 clk = ~clk;
    ajr_setpoint_ramp #(.TICK_CYCLES(100)) i_ajr_setpoint_ramp (.clk, .reset_n, .apb_req,
        .prdata, .pready, .pslverr, .requested_port_flow, .vehicle_speed,
        .ramp_port_flow, .flow_update);
    ajr_partner i_ajr_partner (.clk, .reset_n, .cmd_flow, .cmd_speed,
        .requested_port_flow, .vehicle_speed);
    // ====================
    // run limit, about three times the expected length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            final_report();
        end
    end
    task automatic final_report();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        apb_req <= '{1'b1, 1'b0, w, ad, d};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (!pready && n < 50);
        rd = prdata;
        err = pslverr;
        apb_req <= '0;
    endtask
    function automatic int a(int x);
        return x < 0 ? -x : x;
    endfunction
    // ====================
    // one tick of the model: reverse goes to zero first, abort only from a slow fall
    task automatic model(input int g);
        int t, s;
        t = (cur * g < 0) ? 0 : g;
        if (cur * g < 0 && a(cur) <= lim && a(g) > thr) ab = 1;
        s = a(t) > a(cur) ? 1000 / tr : ab ? 1000 / tra : a(cur) > lim ? 1000 / tfast : 1000 / tf;
        cur = mode == 0 ? g : a(t - cur) <= s ? t : cur + (t > cur ? s : -s);
        if (cur == 0) ab = 0;
    endtask
    task automatic run(input int g, input int n);
        int w;
        for (int k = 1; k <= n; k++) begin
            cmd_flow <= 12'(g);
            w = 0;
            do begin
                @(posedge clk);
                w++;
            end while (!flow_update && w < 300);
            model(g);
            if (prog == 0 || k % 5 == 0)
                `CHK("ramp_port_flow", 12'(prog ? knee[k / 5 - 1] : cur), ramp_port_flow)
        end
    endtask
    initial begin
        void'($urandom(32'h9c4ee972));
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        foreach (rst_v[i]) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            `CHK("register", rst_v[i], rd)
        end
        apb(1'b0, 8'h1c, 32'h0);
        `CHK("pslverr", 1'b1, err)
        v = $urandom;
        apb(1'b1, OFS_CTRL, v);
        apb(1'b0, OFS_CTRL, 32'h0);
        `CHK("ctrl", v & CTRL_MASK, rd)
        apb(1'b1, OFS_CTRL, 32'h0);
        run(0, 1);
        repeat (6) run(int'($urandom_range(2000)) - 1000, 1);
        run(0, 1);
        // ====================
        // fixed ramps: rise, fast then slow fall, abort
        apb(1'b1, OFS_UP, 32'h00c8_000a);
        apb(1'b1, OFS_DOWN, 32'h0014_0014);
        apb(1'b1, OFS_AUX, 32'h000a_000a);
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        {tr, tf, tfast, tra, mode} = {32'd10, 32'd20, 32'd10, 32'd10, 32'd1};
        run(1000, 10);
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK("status", 11'(cur), rd[10:0])
        apb(1'b1, OFS_LIMIT, 32'h0000_0320);
        lim = 800;
        run(0, 18);
        apb(1'b1, OFS_LIMIT, 32'h0064_03e8);
        {lim, thr} = {32'd1000, 32'd100};
        run(1000, 10);
        run(0, 2);
        run(-50, 2);
        run(-300, 12);
        apb(1'b1, OFS_LIMIT, 32'h03e8_03e8);
        thr = 1000;
        run(300, 6);
        // ====================
        // speed ramps with speed beyond the region, then progressive rise
        apb(1'b1, OFS_UP, 32'h0014_000a);
        apb(1'b1, OFS_CTRL, 32'h0000_0002);
        cmd_speed <= -16'sd1000;
        {tr, mode} = {32'd20, 32'd2};
        run(0, 6);
        run(300, 6);
        apb(1'b1, OFS_UP, 32'h0014_0014);
        apb(1'b1, OFS_CTRL, 32'h0000_0a01);
        mode = 1;
        run(0, 6);
        prog = 1;
        run(1000, 20);
        final_report();
    end
endmodule
